// ==== serial_peer.sv ====
// Serial peer model: frame sender and listener on channel 0
`timescale 1ns/10ps
module serial_peer #(
  parameter int BIT_DIV = 4
) (
  input wire logic clk_i, // Clock
  input wire logic txd_i, // Line from the block
  input wire logic inv_i, // Line polarity inverted
  input wire logic listen_i, // Listener armed
  output logic rxd_o, // Line to the block
  output logic [7:0] last_o, // Last byte heard
  output int count_o // Frames heard
);
  logic line;
  assign rxd_o = line ^ inv_i;
  task automatic send(input logic [7:0] b, input logic par);
    logic [10:0] f;
    f = {1'b1, par, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      line <= f[i];
      repeat (BIT_DIV) @(posedge clk_i);
    end
  endtask : send
  // Mid-bit sampling; parity and stop are not judged here
  initial begin
    line = 1'b1;
    last_o = '0;
    count_o = 0;
    forever begin
      @(posedge clk_i);
      if (listen_i && (txd_i ^ inv_i) === 1'b0) begin
        repeat (BIT_DIV / 2) @(posedge clk_i);
        for (int i = 0; i < 8; i++) begin
          repeat (BIT_DIV) @(posedge clk_i);
          last_o[i] = txd_i ^ inv_i;
        end
        repeat (2 * BIT_DIV) @(posedge clk_i);
        count_o++;
      end
    end
  end
endmodule : serial_peer

// ==== tb.sv ====
// Self-checking bench for the UART modem control block
`timescale 1ns/10ps
module tb;
  import uart_mctl_pkg::*;
  localparam int DIV = 4;
  localparam logic [11:0] M0 = MCTL_BASE[0];
  localparam logic [11:0] TX0 = M0 + TXD_DELTA;
  localparam logic [11:0] ST0 = M0 + STAT_DELTA;
  localparam logic [11:0] LC0 = M0 + LCTL_DELTA;
  logic clk, rst, inv, listen, peer_rxd, e;
  apb_req_t req;
  apb_rsp_t rsp;
  modem_in_t [NUM_CH-1:0] modem_pins;
  modem_out_t [NUM_CH-1:0] pins;
  logic [7:0] last;
  logic [31:0] q;
  int count, base, err_count, comparisons;
  uart_modem_control_loopback #(.BIT_DIV(DIV)) dut_u (.sys_clk_i(clk),
    .sys_rst_i(rst), .apb_i(req), .apb_o(rsp),
    .rxd_i({1'b1, peer_rxd}), .modem_i(modem_pins), .pins_o(pins));
  serial_peer #(.BIT_DIV(DIV)) peer_u (.clk_i(clk), .txd_i(pins[0].txd),
    .inv_i(inv), .listen_i(listen), .rxd_o(peer_rxd), .last_o(last),
    .count_o(count));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, output logic [31:0] r, output logic s);
    int n;
    n = 0;
    @(posedge clk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 500);
    if (n >= 500) err_count++;
    r = rsp.prdata;
    s = rsp.pslverr;
    req <= '0;
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic s;
    xfer(1'b1, a, d, r, s);
  endtask : wr
  task automatic rd(input logic [11:0] a, output logic [31:0] r);
    logic s;
    xfer(1'b0, a, 32'h0, r, s);
  endtask : rd
  task automatic wait_rx(output logic [31:0] r);
    int n;
    n = 0;
    do begin
      rd(ST0, r);
      n++;
    end while (r[STAT_RXVALID] !== 1'b1 && n < 200);
    if (r[STAT_RXVALID] !== 1'b1) err_count++;
  endtask : wait_rx
  task automatic conclude();
    $display("Errors %0d, comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : conclude
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    conclude();
  end
  initial begin
    req = '0;
    modem_pins = '1;
    inv = 1'b0;
    listen = 1'b0;
    rst = 1'b1;
    err_count = 0;
    comparisons = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rd(M0, q);
    chk(q, 32'h0);
    rd(MCTL_BASE[1], q);
    chk(q, 32'h0);
    wr(MCTL_BASE[1], 32'h03);
    rd(MCTL_BASE[1], q);
    chk(q, 32'h03);
    chk(pins[1], 5'h13);
    wr(M0, 32'hFF);
    rd(M0, q);
    chk(q, 32'h7F);
    xfer(1'b0, 12'h0C0, 32'h0, q, e);
    chk(e, 1'b1);
    // Status pins take the same value i; a leak shows unless i[3]!=i[1] and i[2]!=i[0]
    for (int i = 0; i < 16; i++) begin
      modem_pins[0] <= modem_in_t'(i[3:0]);
      wr(M0, 32'h10 | i);
      rd(ST0, q);
      chk(q[19:16], {i[3], i[2], i[0], i[1]});
      chk(pins[0], 5'h1F);
      wr(M0, i);
      rd(ST0, q);
      chk(q[19:16], {~i[1], ~i[0], ~i[2], ~i[3]});
      chk(pins[0].rts_n, !i[1]);
      chk(pins[0].dtr_n, !i[0]);
      chk(pins[0][1:0], 2'b11);
    end
    wr(M0, 32'h50);
    fork
      peer_u.send(8'h00, 1'b1);
      wr(TX0, 32'hA5);
    join
    wait_rx(q);
    chk(q[9:0], {2'b01, 8'hA5});
    for (int k = 0; k < 4; k++) begin
      wr(LC0, k & 1);
      wr(M0, 32'h10 | ((k & 2) << 4));
      wr(TX0, 32'h5A);
      wait_rx(q);
      chk(q[9:0], {k[1] & k[0], 1'b1, 8'h5A});
    end
    wr(M0, 32'h40);
    inv <= 1'b1;
    repeat (4) @(posedge clk);
    listen <= 1'b1;
    base = count;
    // Ten bytes overfill the queue, so the last write must wait
    for (int k = 0; k < 10; k++) begin
      wr(TX0, 32'h30 + k);
    end
    for (int n = 0; n < 2000 && count < base + 10; n++) begin
      @(posedge clk);
    end
    chk(count, base + 10);
    chk(last, 8'h39);
    rd(ST0, q);
    chk(q[STAT_EMPTY], 1'b1);
    peer_u.send(8'hC3, ^8'hC3);
    wait_rx(q);
    chk(q[10:0], {3'b001, 8'hC3});
    conclude();
  end
endmodule : tb

// ==== uart_mctl_checker.sv ====
// Assertion checker for the UART modem control block
`timescale 1ns/10ps
module uart_mctl_checker
  import uart_mctl_pkg::*;
(
  input wire logic sys_clk_i, // Clock
  input wire logic sys_rst_i, // Reset
  input wire apb_req_t apb_i, // APB request
  input wire apb_rsp_t apb_o, // APB answer
  input wire logic [NUM_CH-1:0] rxd_i, // Receive pins
  input wire modem_in_t [NUM_CH-1:0] modem_i, // Status pins
  input wire modem_out_t [NUM_CH-1:0] pins_o // Output pins
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic [6:0] mc;
  logic [1:0] age;
  logic done;
  logic wr_mc;
  logic rd_mc;
  logic rd_st;
  assign done = apb_i.psel && apb_i.penable && apb_o.pready;
  assign wr_mc = done && apb_i.pwrite && apb_i.paddr == MCTL_BASE[0];
  assign rd_mc = done && !apb_i.pwrite && apb_i.paddr == MCTL_BASE[0];
  assign rd_st = done && !apb_i.pwrite &&
    apb_i.paddr == MCTL_BASE[0] + STAT_DELTA;
  // Shadow of channel 0 control; age lets pins settle after a write
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      mc <= '0;
      age <= 2'h3;
    end else if (wr_mc) begin
      mc <= apb_i.pwdata[6:0];
      age <= 2'h0;
    end else if (age != 2'h3) begin
      age <= age + 2'h1;
    end
  end
  reserved_bit_a: assert property (
    rd_mc |-> apb_o.prdata == {25'h0, mc})
    else $error("control read back wrong");
  loop_txd_a: assert property (
    mc[4] && age == 2'h3 |-> pins_o[0].txd)
    else $error("txd not high in loopback");
  loop_pins_a: assert property (
    mc[4] && age == 2'h3 |-> pins_o[0][3:0] == 4'hF)
    else $error("modem pins active in loopback");
  aux_idle_a: assert property (
    age == 2'h3 |-> pins_o[0].aux_a_n && pins_o[0].aux_b_n)
    else $error("aux pin active");
  rts_pin_a: assert property (
    !mc[4] && age == 2'h3 |-> pins_o[0].rts_n == !mc[1])
    else $error("rts pin wrong");
  dtr_pin_a: assert property (
    !mc[4] && age == 2'h3 |-> pins_o[0].dtr_n == !mc[0])
    else $error("dtr pin wrong");
  loop_status_a: assert property (
    rd_st && mc[4] |->
      apb_o.prdata[19:16] == {mc[3], mc[2], mc[0], mc[1]})
    else $error("loopback status wrong");
  answer_bound_a: assert property (
    $rose(apb_i.penable) |-> ##[1:400] apb_o.pready)
    else $error("no answer");
  ready_pulse_a: assert property (
    apb_o.pready |=> !apb_o.pready)
    else $error("ready held past one cycle");
endmodule : uart_mctl_checker

bind uart_modem_control_loopback uart_mctl_checker chk_u (
  .sys_clk_i(sys_clk_i),
  .sys_rst_i(sys_rst_i),
  .apb_i(apb_i),
  .apb_o(apb_o),
  .rxd_i(rxd_i),
  .modem_i(modem_i),
  .pins_o(pins_o)
);

// ==== uart_mctl_pkg.sv ====
// Constants, types and register map of the UART modem control block
// What this block does
// - Control bit 7 is reserved, reads zero, writes are ignored.
// - Inversion bit flips both transmit and receive pin polarity.
// - Multidrop bit selects multidrop mode; clear gives normal parity.
// - Multidrop tx parity follows select bit; rx parity must be space.
// - Loopback bit enables internal loopback; clear restores the pins.
// - In loopback the transmit pin is cut from transmit data and held 1.
// - In loopback the receiver takes internal transmit data, not the pin.
// - In loopback modem status comes from the four low control bits.
// - In loopback both auxiliary output pins are driven inactive.
// - aux_a has no normal use; in loopback it shows as carrier detect.
// - aux_b has no normal use; in loopback it shows as ring indicate.
// - Normally the request-to-send pin is the inverse of its control bit.
// - In loopback the request-to-send bit shows as clear-to-send.
// - Normally the terminal-ready pin is the inverse of its control bit.
// - In loopback the terminal-ready bit shows as data-set-ready.
package uart_mctl_pkg;
  localparam int NUM_CH = 2;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 8;
  localparam int FIFO_DEPTH = 8;
  localparam int BIT_CYCLES = 16;
  localparam int TICK_W = 16;
  localparam int TX_BITS = 10;
  localparam int RX_BITS = 10;
  localparam logic [NUM_CH-1:0][ADDR_W-1:0] MCTL_BASE = {12'h0D4, 12'h0C4};
  localparam logic [ADDR_W-1:0] TXD_DELTA = 12'h004;
  localparam logic [ADDR_W-1:0] STAT_DELTA = 12'h008;
  localparam logic [ADDR_W-1:0] LCTL_DELTA = 12'h00C;
  localparam logic [7:0] MCTL_RESET = 8'h00;
  localparam logic [7:0] MCTL_WMASK = 8'h7F;
  localparam int MCTL_DTR = 0;
  localparam int MCTL_RTS = 1;
  localparam int MCTL_AUX_B = 2;
  localparam int MCTL_AUX_A = 3;
  localparam int MCTL_LOOP = 4;
  localparam int MCTL_MULTIDROP = 5;
  localparam int MCTL_INV = 6;
  localparam int LCTL_EVEN_SEL = 0;
  localparam int STAT_RXVALID = 8;
  localparam int STAT_PERR = 9;
  localparam int STAT_FERR = 10;
  localparam int STAT_TXBUSY = 11;
  localparam int STAT_FULL = 12;
  localparam int STAT_EMPTY = 13;
  localparam int STAT_CTS = 16;
  localparam int STAT_DSR = 17;
  localparam int STAT_RI = 18;
  localparam int STAT_DCD = 19;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  typedef struct packed {
    logic cts_n;
    logic dsr_n;
    logic dcd_n;
    logic ri_n;
  } modem_in_t;

  typedef struct packed {
    logic txd;
    logic rts_n;
    logic dtr_n;
    logic aux_a_n;
    logic aux_b_n;
  } modem_out_t;

  typedef struct packed {
    logic [7:0] mctl;
    logic even_parity_select;
    logic tx_busy;
    logic [3:0] tx_cnt;
    logic [TX_BITS-1:0] tx_sh;
    logic tx_line;
    logic rx_busy;
    logic [3:0] rx_cnt;
    logic [RX_BITS-1:0] rx_sh;
    logic [7:0] rx_data;
    logic rx_valid;
    logic rx_perr;
    logic rx_ferr;
    modem_out_t pins;
  } chan_t;

  typedef struct packed {
    chan_t [NUM_CH-1:0] ch;
    logic [TICK_W-1:0] tick_cnt;
    logic tick;
    apb_rsp_t rsp;
  } state_t;
endpackage : uart_mctl_pkg

// ==== uart_modem_control_loopback.sv ====
// Transmit FIFO and the two-channel UART modem control and loopback block
`timescale 1ns/10ps

module uart_tx_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk_i, // System clock
  input wire logic sys_rst_i, // Synchronous reset, high
  input wire logic in_valid_i, // Write request
  output logic in_ready_o, // Room for one word
  input wire logic [WIDTH-1:0] in_data_i, // Write data
  output logic out_valid_o, // Word available
  input wire logic out_ready_i, // Reader takes word
  output logic [WIDTH-1:0] out_data_o // Oldest word
);
  // Depth must be a power of two so pointers wrap by themselves
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } fifo_state_t;

  fifo_state_t st;
  fifo_state_t next_st;
  logic push;
  logic pop;

  assign in_ready_o = (st.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (st.cnt != '0);
  assign out_data_o = st.mem[st.rp];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_ready_i && out_valid_o;

  always_comb begin
    next_st = st;
    if (push) begin
      next_st.mem[st.wp] = in_data_i;
      next_st.wp = st.wp + AW'(1);
    end
    if (pop) begin
      next_st.rp = st.rp + AW'(1);
    end
    case ({push, pop})
      2'b10: next_st.cnt = st.cnt + (AW+1)'(1);
      2'b01: next_st.cnt = st.cnt - (AW+1)'(1);
      default: next_st.cnt = st.cnt;
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : uart_tx_fifo

module uart_modem_control_loopback
  import uart_mctl_pkg::*;
#(
  parameter int BIT_DIV = BIT_CYCLES,
  parameter int TXQ_DEPTH = FIFO_DEPTH
) (
  input wire logic sys_clk_i, // System clock, 125 MHz
  input wire logic sys_rst_i, // Synchronous reset, high
  input wire apb_req_t apb_i, // APB request from master
  output apb_rsp_t apb_o, // APB answer
  input wire logic [NUM_CH-1:0] rxd_i, // Serial receive pins
  input wire modem_in_t [NUM_CH-1:0] modem_i, // Modem status pins
  output modem_out_t [NUM_CH-1:0] pins_o // Serial and modem outputs
);
  state_t st;
  state_t next_st;

  logic [NUM_CH-1:0] q_in_valid;
  logic [NUM_CH-1:0] q_in_ready;
  logic [NUM_CH-1:0] q_out_valid;
  logic [NUM_CH-1:0] q_out_ready;
  logic [NUM_CH-1:0][DATA_W-1:0] q_out_data;
  logic [NUM_CH-1:0] loop_on;
  logic [NUM_CH-1:0] rx_in;
  logic [NUM_CH-1:0][3:0] mstat;
  logic acc;
  logic done;

  assign apb_o = st.rsp;
  assign acc = apb_i.psel && apb_i.penable;
  // Write side effects only at the edge where pready is sampled high
  assign done = acc && st.rsp.pready;

  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      assign loop_on[g] = st.ch[g].mctl[MCTL_LOOP];
      // Loopback feeds the receiver before any pin inversion
      assign rx_in[g] = loop_on[g] ? st.ch[g].tx_line
                      : (rxd_i[g] ^ st.ch[g].mctl[MCTL_INV]);
      // Order of mstat bits: dcd, ri, dsr, cts
      assign mstat[g] = loop_on[g] ?
        {st.ch[g].mctl[MCTL_AUX_A],
         st.ch[g].mctl[MCTL_AUX_B],
         st.ch[g].mctl[MCTL_DTR],
         st.ch[g].mctl[MCTL_RTS]}
        : ~{modem_i[g].dcd_n, modem_i[g].ri_n,
            modem_i[g].dsr_n, modem_i[g].cts_n};
      assign q_in_valid[g] = done && apb_i.pwrite &&
        (apb_i.paddr == MCTL_BASE[g] + TXD_DELTA);
      // Shifter only drains at a bit tick while idle
      assign q_out_ready[g] = st.tick && !st.ch[g].tx_busy;

      uart_tx_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(TXQ_DEPTH)
      ) u_txq (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .in_valid_i(q_in_valid[g]),
        .in_ready_o(q_in_ready[g]),
        .in_data_i(apb_i.pwdata[DATA_W-1:0]),
        .out_valid_o(q_out_valid[g]),
        .out_ready_i(q_out_ready[g]),
        .out_data_o(q_out_data[g])
      );
    end
  endgenerate

  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;

    // Bit rate enable, one pulse every BIT_DIV cycles
    if (st.tick_cnt == TICK_W'(BIT_DIV - 1)) begin
      next_st.tick_cnt = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.tick_cnt = st.tick_cnt + TICK_W'(1);
    end

    // Access phase, first cycle: prepare the answer
    next_st.rsp.pready = 1'b0;
    if (acc && !st.rsp.pready) begin
      next_st.rsp.pready = 1'b1;
      next_st.rsp.pslverr = 1'b1;
      next_st.rsp.prdata = '0;
      for (int c = 0; c < NUM_CH; c++) begin
        if (apb_i.paddr == MCTL_BASE[c]) begin
          next_st.rsp.pslverr = 1'b0;
          next_st.rsp.prdata[7:0] = st.ch[c].mctl & MCTL_WMASK;
        end
        if (apb_i.paddr == MCTL_BASE[c] + TXD_DELTA) begin
          next_st.rsp.pslverr = 1'b0;
          // Full queue stretches the access phase: no byte is dropped
          if (apb_i.pwrite && !q_in_ready[c]) begin
            next_st.rsp.pready = 1'b0;
          end
        end
        if (apb_i.paddr == MCTL_BASE[c] + LCTL_DELTA) begin
          next_st.rsp.pslverr = 1'b0;
          next_st.rsp.prdata[LCTL_EVEN_SEL] =
            st.ch[c].even_parity_select;
        end
        if (apb_i.paddr == MCTL_BASE[c] + STAT_DELTA) begin
          next_st.rsp.pslverr = 1'b0;
          next_st.rsp.prdata[7:0] = st.ch[c].rx_data;
          next_st.rsp.prdata[STAT_RXVALID] = st.ch[c].rx_valid;
          next_st.rsp.prdata[STAT_PERR] = st.ch[c].rx_perr;
          next_st.rsp.prdata[STAT_FERR] = st.ch[c].rx_ferr;
          next_st.rsp.prdata[STAT_TXBUSY] = st.ch[c].tx_busy;
          next_st.rsp.prdata[STAT_FULL] = !q_in_ready[c];
          next_st.rsp.prdata[STAT_EMPTY] = !q_out_valid[c];
          next_st.rsp.prdata[STAT_CTS] = mstat[c][0];
          next_st.rsp.prdata[STAT_DSR] = mstat[c][1];
          next_st.rsp.prdata[STAT_RI] = mstat[c][2];
          next_st.rsp.prdata[STAT_DCD] = mstat[c][3];
          // Cleared when snapshot is taken so a later byte stays flagged
          if (!apb_i.pwrite) begin
            next_st.ch[c].rx_valid = 1'b0;
          end
        end
      end
    end

    for (int c = 0; c < NUM_CH; c++) begin
      // Register writes
      if (done && apb_i.pwrite && apb_i.paddr == MCTL_BASE[c]) begin
        next_st.ch[c].mctl = apb_i.pwdata[7:0] & MCTL_WMASK;
      end
      if (done && apb_i.pwrite &&
          apb_i.paddr == MCTL_BASE[c] + LCTL_DELTA) begin
        next_st.ch[c].even_parity_select = apb_i.pwdata[LCTL_EVEN_SEL];
      end

      // Transmit shifter: start, 8 data, parity, stop
      if (q_out_ready[c] && q_out_valid[c]) begin
        next_st.ch[c].tx_busy = 1'b1;
        next_st.ch[c].tx_line = 1'b0;
        next_st.ch[c].tx_cnt = 4'(TX_BITS);
        next_st.ch[c].tx_sh[7:0] = q_out_data[c];
        if (st.ch[c].mctl[MCTL_MULTIDROP]) begin
          // Select bit gives mark or space directly
          next_st.ch[c].tx_sh[8] = st.ch[c].even_parity_select;
        end else begin
          next_st.ch[c].tx_sh[8] =
            (^q_out_data[c]) ^ !st.ch[c].even_parity_select;
        end
        next_st.ch[c].tx_sh[9] = 1'b1;
      end else if (st.tick && st.ch[c].tx_busy) begin
        if (st.ch[c].tx_cnt == 4'h0) begin
          next_st.ch[c].tx_busy = 1'b0;
          next_st.ch[c].tx_line = 1'b1;
        end else begin
          next_st.ch[c].tx_line = st.ch[c].tx_sh[0];
          next_st.ch[c].tx_sh = {1'b1, st.ch[c].tx_sh[TX_BITS-1:1]};
          next_st.ch[c].tx_cnt = st.ch[c].tx_cnt - 4'h1;
        end
      end

      // Receiver, one sample per bit tick
      if (st.tick) begin
        if (!st.ch[c].rx_busy) begin
          if (!rx_in[c]) begin
            next_st.ch[c].rx_busy = 1'b1;
            next_st.ch[c].rx_cnt = 4'(RX_BITS);
          end
        end else if (st.ch[c].rx_cnt != 4'h0) begin
          next_st.ch[c].rx_sh = {rx_in[c], st.ch[c].rx_sh[RX_BITS-1:1]};
          next_st.ch[c].rx_cnt = st.ch[c].rx_cnt - 4'h1;
        end
      end
      // Frame complete: set wins over a same-cycle read clear
      if (st.ch[c].rx_busy && st.ch[c].rx_cnt == 4'h0) begin
        next_st.ch[c].rx_busy = 1'b0;
        next_st.ch[c].rx_data = st.ch[c].rx_sh[7:0];
        next_st.ch[c].rx_valid = 1'b1;
        next_st.ch[c].rx_ferr = !st.ch[c].rx_sh[9];
        if (st.ch[c].mctl[MCTL_MULTIDROP]) begin
          // Space expected; a mark flags an address byte
          next_st.ch[c].rx_perr = st.ch[c].rx_sh[8];
        end else begin
          next_st.ch[c].rx_perr = st.ch[c].rx_sh[8] !=
            ((^st.ch[c].rx_sh[7:0]) ^ !st.ch[c].even_parity_select);
        end
      end

      // Pin drivers, registered
      if (loop_on[c]) begin
        next_st.ch[c].pins.txd = 1'b1;
        next_st.ch[c].pins.rts_n = 1'b1;
        next_st.ch[c].pins.dtr_n = 1'b1;
      end else begin
        next_st.ch[c].pins.txd =
          st.ch[c].tx_line ^ st.ch[c].mctl[MCTL_INV];
        next_st.ch[c].pins.rts_n = !st.ch[c].mctl[MCTL_RTS];
        next_st.ch[c].pins.dtr_n = !st.ch[c].mctl[MCTL_DTR];
      end
      // Auxiliary bits never reach pins, so these stay inactive
      next_st.ch[c].pins.aux_a_n = 1'b1;
      next_st.ch[c].pins.aux_b_n = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      st <= '0;
      for (int c = 0; c < NUM_CH; c++) begin
        st.ch[c].mctl <= MCTL_RESET;
        st.ch[c].tx_line <= 1'b1;
        st.ch[c].pins <= '1;
      end
    end else begin
      st <= next_st;
    end
  end

  generate
    for (g = 0; g < NUM_CH; g++) begin : g_pin
      assign pins_o[g] = st.ch[g].pins;
    end
  endgenerate
endmodule : uart_modem_control_loopback
